// ===== design/hpp_map.vh
// field positions, widths and codes of the host register-access port
`ifndef HPP_MAP_VH
`define HPP_MAP_VH

// bus widths
`define HPP_ADDR_W 14
`define HPP_DATA_W 8

// shared data pins used by the serial functions
`define HPP_PIN_CPOL 7
`define HPP_PIN_CPHA 6
`define HPP_PIN_SWAP 5
`define HPP_PIN_SCLK 2
`define HPP_PIN_MOSI 1
`define HPP_PIN_MISO 0

// serial control word: read flag, 14 address bits, burst flag, then data
`define HPP_CW_RW_POS 5'h00
`define HPP_CW_ADDR_FIRST 5'h01
`define HPP_CW_ADDR_LAST 5'h0e
`define HPP_CW_BURST_POS 5'h0f
`define HPP_CW_DATA_FIRST 5'h10
`define HPP_CW_DATA_LAST 5'h17
`define HPP_CW_DONE 5'h18

// pin output enables
`define HPP_OE_NONE 8'h00
`define HPP_OE_ALL 8'hff
`define HPP_OE_MISO 8'h01

`endif

// ===== design/hpp_sync.v
// two-flip-flop synchroniser for a group of pin inputs
module hpp_sync #(
  parameter WIDTH = 1
) (
  input wire clk_i,               // block clock
  input wire rst_i,               // async reset, active high
  input wire [WIDTH-1:0] async_i, // pins from outside the clock domain
  input wire [WIDTH-1:0] rst_val_i, // not used; both stages reset to all ones
  output reg [WIDTH-1:0] sync_o   // synchronised copy
);

  reg [WIDTH-1:0] meta_reg;

  // first stage is read by the second stage only
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= {WIDTH{1'b1}};
      sync_o <= {WIDTH{1'b1}};
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end

endmodule // hpp_sync

// ===== design/hpp_port.v
// host register-access port: parallel strobe bus or slave serial port
`include "hpp_map.vh"

module hpp_port #(
  parameter ADDR_W = `HPP_ADDR_W,
  parameter DATA_W = `HPP_DATA_W
) (
  input wire clk_i,                    // 100 MHz block clock
  input wire rst_i,                    // async reset, active high
  input wire [DATA_W-1:0] data_pin_i,  // shared data pins, level seen
  output reg [DATA_W-1:0] data_pin_o,  // value driven onto data pins
  output reg [DATA_W-1:0] data_pin_oe_o, // high where block drives pin
  input wire [ADDR_W-1:0] addr_pin_i,  // parallel register address
  input wire chip_select_n_i,          // chip select, active low
  input wire read_strobe_n_i,          // read or data strobe, low
  input wire write_strobe_n_i,         // write strobe or read/write flag
  input wire serial_port_sel_i,        // 1 serial, 0 parallel
  input wire bus_timing_select_i,      // 1 data-strobe timing
  output reg [ADDR_W-1:0] reg_addr_o,  // register address to core
  output reg [DATA_W-1:0] reg_wdata_o, // write data to core
  output reg reg_wr_o,                 // one-cycle write pulse
  output reg reg_rd_o,                 // one-cycle read pulse
  input wire [DATA_W-1:0] reg_rdata_i, // read data, valid cycle after rd
  output reg serial_mode_o             // serial mode in force
);

  // parallel read sequencer states
  localparam PS_IDLE = 2'h0;
  localparam PS_FETCH = 2'h1;
  localparam PS_DRIVE = 2'h2;
  localparam SYNC_W = DATA_W + ADDR_W + 5;

  // next bit of a shifting-in byte, order chosen by the swap setting
  function [DATA_W-1:0] hpp_shift_in;
    input [DATA_W-1:0] cur;
    input din;
    input msb_first;
    begin
      if (msb_first) begin
        hpp_shift_in = {cur[DATA_W-2:0], din};
      end else begin
        hpp_shift_in = {din, cur[DATA_W-1:1]};
      end
    end
  endfunction

  // bit to present next when shifting a byte out
  function hpp_out_bit;
    input [DATA_W-1:0] cur;
    input msb_first;
    begin
      if (msb_first) begin
        hpp_out_bit = cur[DATA_W-1];
      end else begin
        hpp_out_bit = cur[0];
      end
    end
  endfunction

  // byte after one bit has gone out
  function [DATA_W-1:0] hpp_shift_out;
    input [DATA_W-1:0] cur;
    input msb_first;
    begin
      if (msb_first) begin
        hpp_shift_out = {cur[DATA_W-2:0], 1'b0};
      end else begin
        hpp_shift_out = {1'b0, cur[DATA_W-1:1]};
      end
    end
  endfunction

  wire [SYNC_W-1:0] pins_async;
  wire [SYNC_W-1:0] pins_s;
  wire [DATA_W-1:0] data_s;
  wire [ADDR_W-1:0] addr_s;
  wire cs_n_s;
  wire rd_n_s;
  wire wr_n_s;
  wire sel_s;
  wire bts_s;

  // every pin passes two flops before any logic looks at it
  assign pins_async = {data_pin_i, addr_pin_i, chip_select_n_i,
                       read_strobe_n_i, write_strobe_n_i,
                       serial_port_sel_i, bus_timing_select_i};

  hpp_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(pins_async),
    .rst_val_i({SYNC_W{1'b1}}),
    .sync_o(pins_s)
  );

  assign data_s = pins_s[SYNC_W-1:ADDR_W+5];
  assign addr_s = pins_s[ADDR_W+4:5];
  assign cs_n_s = pins_s[4];
  assign rd_n_s = pins_s[3];
  assign wr_n_s = pins_s[2];
  assign sel_s = pins_s[1];
  assign bts_s = pins_s[0];

  reg cs_n_d_reg;
  reg rd_n_d_reg;
  reg sclk_d_reg;
  reg wr_n_d_reg;
  reg [1:0] p_state_reg;
  reg cfg_cpol_reg;
  reg cfg_cpha_reg;
  reg cfg_msb_reg;
  reg [4:0] bit_cnt_reg;
  reg rw_flag_reg;
  reg burst_flag_reg;
  reg [ADDR_W-1:0] s_addr_reg;
  reg [DATA_W-1:0] s_data_reg;
  reg [DATA_W-1:0] tx_reg;
  reg inc_pend_reg;
  reg rd_pend_reg;
  reg rd_cap_reg;

  wire sclk_s;
  wire mosi_s;
  wire sclk_rise;
  wire sclk_fall;
  wire samp_edge;
  wire shift_edge;
  wire ser_active;
  wire ser_start;
  wire par_read;
  wire par_write;
  wire [DATA_W-1:0] s_data_next;

  assign sclk_s = data_s[`HPP_PIN_SCLK];
  assign mosi_s = data_s[`HPP_PIN_MOSI];
  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign sclk_fall = ~sclk_s & sclk_d_reg;
  // equal polarity and phase samples on the rising edge
  assign samp_edge = (cfg_cpol_reg == cfg_cpha_reg) ? sclk_rise
                                                    : sclk_fall;
  assign shift_edge = (cfg_cpol_reg == cfg_cpha_reg) ? sclk_fall
                                                     : sclk_rise;
  assign ser_active = sel_s & ~cs_n_s;
  assign ser_start = sel_s & ~cs_n_s & cs_n_d_reg;
  assign s_data_next = hpp_shift_in(s_data_reg, mosi_s, cfg_msb_reg);

  // strobes count only with select low; data-strobe timing reads the
  // write pin as a read/write flag, high meaning read
  assign par_read = ~sel_s & ~cs_n_s & ~rd_n_s &
                    (bts_s ? wr_n_s : 1'b1);
  assign par_write = ~sel_s & ~cs_n_s &
                     (bts_s ? (rd_n_s & ~rd_n_d_reg & ~wr_n_s)
                            : (wr_n_s & ~wr_n_d_reg));

  // edge history of the synchronised strobes and serial clock
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_n_d_reg <= 1'b1;
      rd_n_d_reg <= 1'b1;
      wr_n_d_reg <= 1'b1;
      sclk_d_reg <= 1'b1; // sync resets high, so no false edge
    end else begin
      cs_n_d_reg <= cs_n_s;
      rd_n_d_reg <= rd_n_s;
      wr_n_d_reg <= wr_n_s;
      sclk_d_reg <= sclk_s;
    end
  end

  // serial settings caught once per frame, so mid-frame pin wiggles on
  // the config pins cannot reshape a transfer in flight
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_cpol_reg <= 1'b0;
      cfg_cpha_reg <= 1'b0;
      cfg_msb_reg <= 1'b0;
      serial_mode_o <= 1'b0;
    end else begin
      serial_mode_o <= sel_s;
      if (ser_start) begin
        cfg_cpol_reg <= data_s[`HPP_PIN_CPOL];
        cfg_cpha_reg <= data_s[`HPP_PIN_CPHA];
        cfg_msb_reg <= data_s[`HPP_PIN_SWAP];
      end
    end
  end

  // serial control word and data assembly
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_cnt_reg <= 5'h00;
      rw_flag_reg <= 1'b0;
      burst_flag_reg <= 1'b0;
      s_addr_reg <= {ADDR_W{1'b0}};
      s_data_reg <= {DATA_W{1'b0}};
    end else if (!ser_active) begin
      bit_cnt_reg <= 5'h00;
    end else if (samp_edge && bit_cnt_reg != `HPP_CW_DONE) begin
      // flag positions are fixed; only the fields obey the swap bit
      if (bit_cnt_reg == `HPP_CW_RW_POS) begin
        rw_flag_reg <= mosi_s;
      end else if (bit_cnt_reg <= `HPP_CW_ADDR_LAST) begin
        if (cfg_msb_reg) begin
          s_addr_reg <= {s_addr_reg[ADDR_W-2:0], mosi_s};
        end else begin
          s_addr_reg <= {mosi_s, s_addr_reg[ADDR_W-1:1]};
        end
      end else if (bit_cnt_reg == `HPP_CW_BURST_POS) begin
        burst_flag_reg <= mosi_s;
      end else begin
        s_data_reg <= s_data_next;
      end
      if (bit_cnt_reg == `HPP_CW_DATA_LAST && burst_flag_reg) begin
        bit_cnt_reg <= `HPP_CW_DATA_FIRST;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
    end
  end

  // register port, parallel read sequencer and pin drivers share one
  // process so that each output has a single driver
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      p_state_reg <= PS_IDLE;
      reg_addr_o <= {ADDR_W{1'b0}};
      reg_wdata_o <= {DATA_W{1'b0}};
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      data_pin_o <= {DATA_W{1'b0}};
      data_pin_oe_o <= `HPP_OE_NONE;
      tx_reg <= {DATA_W{1'b0}};
      inc_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      rd_cap_reg <= 1'b0;
    end else begin
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      rd_cap_reg <= reg_rd_o;
      rd_pend_reg <= 1'b0;
      inc_pend_reg <= 1'b0;
      if (!sel_s) begin
        // parallel mode: serial settings play no part here
        tx_reg <= {DATA_W{1'b0}};
        if (par_write) begin
          reg_addr_o <= addr_s;
          reg_wdata_o <= data_s;
          reg_wr_o <= 1'b1;
        end
        case (p_state_reg)
          PS_IDLE: begin
            data_pin_oe_o <= `HPP_OE_NONE;
            if (par_read) begin
              reg_addr_o <= addr_s;
              reg_rd_o <= 1'b1;
              p_state_reg <= PS_FETCH;
            end
          end
          PS_FETCH: begin
            if (rd_cap_reg) begin
              data_pin_o <= reg_rdata_i;
              data_pin_oe_o <= `HPP_OE_ALL;
              p_state_reg <= PS_DRIVE;
            end
          end
          PS_DRIVE: begin
            // release as soon as select or strobe goes away
            if (!par_read) begin
              data_pin_oe_o <= `HPP_OE_NONE;
              p_state_reg <= PS_IDLE;
            end
          end
          default: begin
            data_pin_oe_o <= `HPP_OE_NONE;
            p_state_reg <= PS_IDLE;
          end
        endcase
      end else begin
        p_state_reg <= PS_IDLE;
        if (!ser_active) begin
          // nothing driven outside a serial frame
          data_pin_oe_o <= `HPP_OE_NONE;
        end else begin
          data_pin_oe_o <= `HPP_OE_MISO;
          // whole address known: start a read fetch
          if (samp_edge && bit_cnt_reg == `HPP_CW_BURST_POS) begin
            reg_addr_o <= s_addr_reg;
            reg_rd_o <= rw_flag_reg;
          end
          // last data bit in: write it, then step the address in burst
          if (samp_edge && bit_cnt_reg == `HPP_CW_DATA_LAST) begin
            if (!rw_flag_reg) begin
              reg_wdata_o <= s_data_next;
              reg_wr_o <= 1'b1;
            end
            inc_pend_reg <= burst_flag_reg;
          end
          if (inc_pend_reg) begin
            reg_addr_o <= reg_addr_o + {{(ADDR_W-1){1'b0}}, 1'b1};
            rd_pend_reg <= rw_flag_reg;
          end
          if (rd_pend_reg) begin
            reg_rd_o <= 1'b1;
          end
          // read data arrives a cycle after the fetch pulse
          if (rd_cap_reg) begin
            tx_reg <= reg_rdata_i;
          end else if (shift_edge &&
                       bit_cnt_reg >= `HPP_CW_DATA_FIRST &&
                       bit_cnt_reg != `HPP_CW_DONE && rw_flag_reg) begin
            data_pin_o[`HPP_PIN_MISO] <=
              hpp_out_bit(tx_reg, cfg_msb_reg);
            tx_reg <= hpp_shift_out(tx_reg, cfg_msb_reg);
          end
        end
      end
    end
  end

endmodule // hpp_port

// ===== verification/hpp_core_model.sv
// register core model answering the port's core-side strobes
module hpp_core_model (
  input wire clk_i, // block clock
  input wire rst_i, // async reset, active high
  input wire [13:0] reg_addr_i, // register address from port
  input wire [7:0] reg_wdata_i, // write data from port
  input wire reg_wr_i, // one-cycle write pulse
  input wire reg_rd_i, // one-cycle read pulse
  output logic [7:0] reg_rdata_o // read data, one cycle after pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:15]; // low address nibble only, enough for the bench

  // eight-bit store and fetch, one-cycle read latency
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      if (reg_wr_i) begin
        mem[reg_addr_i[3:0]] <= reg_wdata_i;
      end
      if (reg_rd_i) begin
        reg_rdata_o <= mem[reg_addr_i[3:0]];
      end
    end
  end
endmodule // hpp_core_model

// ===== verification/hpp_port_asserts.sv
// concurrent checks on the host port's pin drive and core strobes
module hpp_port_asserts (
  input wire clk_i, // block clock
  input wire rst_i, // async reset, active high
  input wire chip_select_n_i, // chip select, active low
  input wire [7:0] data_pin_o, // pin drive value
  input wire [7:0] data_pin_oe_o, // pin drive enables
  input wire [7:0] reg_rdata_i, // core read data
  input wire reg_wr_o, // write pulse
  input wire reg_rd_o, // read pulse
  input wire serial_mode_o // serial mode in force
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // deselected for a while means hands off the bus
  a_idle_no_drive: assert property (
    chip_select_n_i [*6] |-> data_pin_oe_o == 8'h00)
    else $error("pins driven while deselected");
  a_oe_codes_only: assert property (
    data_pin_oe_o inside {8'h00, 8'hff, 8'h01})
    else $error("odd pin enable pattern");
  a_serial_one_pin: assert property (
    serial_mode_o |-> data_pin_oe_o != 8'hff)
    else $error("whole bus driven in serial mode");
  a_par_whole_bus: assert property (
    !serial_mode_o && data_pin_oe_o != 8'h00 |-> data_pin_oe_o == 8'hff)
    else $error("partial bus drive in parallel mode");
  a_wr_single: assert property (
    reg_wr_o |=> !reg_wr_o)
    else $error("write pulse longer than a cycle");
  // strobes count only behind a low select, two sync stages back
  a_wr_needs_cs: assert property (
    reg_wr_o |-> !$past(chip_select_n_i, 2))
    else $error("write without chip select");
  a_rd_needs_cs: assert property (
    reg_rd_o |-> !$past(chip_select_n_i, 2))
    else $error("read without chip select");
  a_read_drives_data: assert property (
    !serial_mode_o && $rose(data_pin_oe_o[7])
      |-> data_pin_o == $past(reg_rdata_i))
    else $error("bus not showing fetched register");
endmodule // hpp_port_asserts

bind hpp_port hpp_port_asserts u_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .chip_select_n_i(chip_select_n_i),
  .data_pin_o(data_pin_o),
  .data_pin_oe_o(data_pin_oe_o),
  .reg_rdata_i(reg_rdata_i),
  .reg_wr_o(reg_wr_o),
  .reg_rd_o(reg_rd_o),
  .serial_mode_o(serial_mode_o)
);

// ===== verification/test_hpp_port.sv
// self-checking bench for the host register-access port
module test_hpp_port;
  timeunit 1ns;
  timeprecision 100ps;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  err_total++; $display("wrong value at %0t: %h vs %h", $time, a, b); \
  end end
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] host_d = 8'h00;
  logic [7:0] host_en = 8'h00;
  logic [7:0] flt = 8'h00;
  logic [13:0] addr = 14'h0000;
  logic cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, sel = 1'b0, bus_timing_select = 1'b0;
  logic cpol = 1'b0, cpha = 1'b0, msb = 1'b0;
  logic [13:0] last_wa = 14'h0000;
  logic [7:0] last_wd = 8'h00;
  wire [7:0] pin_lvl, dout, doe, wdata, rdata;
  wire [13:0] raddr;
  wire wr, rd, smode;
  int err_total = 0, samples_checked = 0, cyc = 0, wcnt = 0;

  // released bits wander so a stale value cannot pass
  assign pin_lvl = (doe & dout) | (~doe & host_en & host_d)
    | (~doe & ~host_en & flt);

  hpp_port dut (.clk_i(clk_i), .rst_i(rst_i), .data_pin_i(pin_lvl),
    .data_pin_o(dout), .data_pin_oe_o(doe), .addr_pin_i(addr),
    .chip_select_n_i(cs_n), .read_strobe_n_i(rd_n),
    .write_strobe_n_i(wr_n), .serial_port_sel_i(sel),
    .bus_timing_select_i(bus_timing_select),
    .reg_addr_o(raddr), .reg_wdata_o(wdata),
    .reg_wr_o(wr), .reg_rd_o(rd), .reg_rdata_i(rdata),
    .serial_mode_o(smode));
  hpp_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(raddr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata));

  always #5 clk_i = ~clk_i;
  // record every core write and cut a hang short
  always @(posedge clk_i) begin
    flt <= ~flt;
    cyc++;
    if (wr) begin
      wcnt++;
      last_wa = raddr;
      last_wd = wdata;
    end
    if (cyc == 30000) begin
      err_total++;
      give_verdict();
    end
  end

  task give_verdict;
    if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task pw(input logic [13:0] a, input logic [7:0] d);
    int n0;
    n0 = wcnt;
    addr = a;
    host_d = d;
    host_en = 8'hff;
    cs_n = 1'b0;
    step(4);
    wr_n = 1'b0;
    step(4);
    wr_n = 1'b1;
    step(6);
    cs_n = 1'b1;
    host_en = 8'h00;
    step(2);
    `CHK(wcnt, n0 + 1)
    `CHK(last_wa, a)
    `CHK(last_wd, d)
  endtask

  task pr(input logic [13:0] a, input logic [7:0] e);
    addr = a;
    cs_n = 1'b0;
    rd_n = 1'b0;
    step(8);
    `CHK(doe, 8'hff)
    `CHK(pin_lvl, e)
    rd_n = 1'b1;
    cs_n = 1'b1;
    step(6);
    `CHK(doe, 8'h00)
  endtask

  // strobes alone, select held high
  task no_cs;
    int n0;
    n0 = wcnt;
    host_en = 8'hff;
    host_d = 8'h3c;
    wr_n = 1'b0;
    step(4);
    wr_n = 1'b1;
    step(4);
    host_en = 8'h00;
    rd_n = 1'b0;
    step(8);
    `CHK(doe, 8'h00)
    rd_n = 1'b1;
    `CHK(wcnt, n0)
  endtask

  // data-strobe timing: write pin acts as the read/write flag
  task ds_io(input logic [13:0] a, input logic [7:0] d);
    int n0;
    n0 = wcnt;
    bus_timing_select = 1'b1;
    addr = a;
    host_d = d;
    host_en = 8'hff;
    wr_n = 1'b0;
    step(4);
    cs_n = 1'b0;
    rd_n = 1'b0;
    step(4);
    rd_n = 1'b1;
    step(6);
    cs_n = 1'b1;
    wr_n = 1'b1;
    host_en = 8'h00;
    step(2);
    `CHK(wcnt, n0 + 1)
    `CHK(last_wa, a)
    `CHK(last_wd, d)
    cs_n = 1'b0;
    rd_n = 1'b0;
    step(8);
    `CHK(doe, 8'hff)
    `CHK(pin_lvl, d)
    rd_n = 1'b1;
    cs_n = 1'b1;
    step(6);
    `CHK(doe, 8'h00)
    bus_timing_select = 1'b0;
    step(4);
  endtask

  // link clock runs only inside frames, 125 ns period
  task sbit(input logic b, output logic r);
    if (!cpha) begin
      host_d[1] = b;
      #62.5 r = pin_lvl[0];
      host_d[2] = ~cpol;
      #62.5 host_d[2] = cpol;
    end else begin
      host_d[2] = ~cpol;
      host_d[1] = b;
      #62.5 r = pin_lvl[0];
      host_d[2] = cpol;
      #62.5;
    end
  endtask

  task sframe(input logic w, input logic b, input logic [13:0] a,
    input logic [7:0] d, output logic [7:0] q);
    logic r;
    int i;
    host_d = {cpol, cpha, msb, 2'b00, cpol, 2'b00};
    host_en = 8'hfe;
    step(4);
    cs_n = 1'b0;
    step(5);
    host_d[7:5] = ~host_d[7:5];
    sbit(!w, r);
    for (i = 0; i < 14; i++) sbit(msb ? a[13 - i] : a[i], r);
    sbit(b, r);
    for (i = 0; i < 8; i++) begin
      sbit(msb ? d[7 - i] : d[i], r);
      q[msb ? 7 - i : i] = r;
    end
    // burst frames carry the inverted byte to the stepped address
    if (b) begin
      for (i = 0; i < 8; i++) sbit(msb ? ~d[7 - i] : ~d[i], r);
    end
    step(6);
    cs_n = 1'b1;
    step(6);
  endtask

  // every polarity, phase and bit order: write then read back
  task serial_modes;
    logic [7:0] q, d;
    logic [13:0] a;
    int k, n0;
    sel = 1'b1;
    step(6);
    `CHK(smode, 1'b1)
    for (k = 0; k < 8; k++) begin
      {cpol, cpha, msb} = k[2:0];
      // low nibbles 8 to f keep clear of the parallel test registers
      a = 14'h1238 + 14'(k);
      d = 8'h96 ^ {k[2:0], 2'b01, k[2:0]};
      sframe(1'b1, 1'b0, a, d, q);
      `CHK(last_wa, a)
      `CHK(last_wd, d)
      sframe(1'b0, 1'b0, a, 8'h00, q);
      `CHK(q, d)
    end
    // burst write of two bytes, second read back from stepped address
    n0 = wcnt;
    sframe(1'b1, 1'b1, 14'h3c01, 8'h4b, q);
    `CHK(wcnt, n0 + 2)
    `CHK(last_wa, 14'h3c02)
    `CHK(last_wd, 8'hb4)
    sframe(1'b0, 1'b0, 14'h3c02, 8'h00, q);
    `CHK(q, 8'hb4)
    host_en = 8'h00;
    sel = 1'b0;
    step(6);
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    #1 rst_i = 1'b0;
    step(5);
    pw(14'h2005, 8'h5a);
    pw(14'h0006, 8'ha3);
    pr(14'h2005, 8'h5a);
    pr(14'h0006, 8'ha3);
    no_cs();
    ds_io(14'h1003, 8'h6c);
    serial_modes();
    pr(14'h0006, 8'ha3);
    give_verdict();
  end
endmodule // test_hpp_port
